/* File: dbv_pkg.sv */
// Package: register map, field layout and voltage constants for the dual buck control bank
package dbv_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CH1_VSEL  = 8'h00;
  localparam logic [7:0] OFS_CH2_VSEL  = 8'h01;
  localparam logic [7:0] OFS_CH1_CMD   = 8'h02;
  localparam logic [7:0] OFS_CH2_CMD   = 8'h03;
  localparam logic [7:0] OFS_SYS_COND  = 8'h04;
  // Field positions
  localparam int GO_BIT       = 7;
  localparam int SLEW_LSB     = 4;
  localparam int MODE_LSB     = 1;
  localparam int OFF_BIT      = 0;
  localparam int TEMP_BIT     = 2;
  localparam int PG2_BIT      = 1;
  localparam int PG1_BIT      = 0;
  // Masks and reset values
  localparam logic [7:0] VSEL_RESET   = 8'h00;
  localparam logic [7:0] CMD_RESET    = 8'h00;
  localparam logic [7:0] CMD_WR_MASK  = 8'h77;
  // Bus address, low two bits chosen by strap
  localparam logic [6:0] BUS_ADDR_BASE = 7'h60;
  localparam logic [1:0] STRAP_GND     = 2'h0;
  localparam logic [1:0] STRAP_HIGH    = 2'h1;
  localparam logic [1:0] STRAP_OPEN    = 2'h2;
  // Light-load mode field codes
  localparam logic [1:0] MODE_PIN      = 2'h0;
  localparam logic [1:0] MODE_FORCED   = 2'h1;
  localparam logic [1:0] MODE_AUTO     = 2'h2;
  // Voltage step and endpoints in millivolts
  localparam int VSTEP_MV  = 10;
  localparam int VMIN_MV   = 680;
  localparam int VMAX_MV   = 1950;
  // Per-channel control to the analog side
  typedef struct packed {
    logic [6:0] target_code;  // Slewed voltage code
    logic       fixed_freq;   // 1: fixed-frequency, 0: pulse skipping allowed
    logic       output_off;   // Output disabled
  } dbv_chan_ctrl_t;
endpackage : dbv_pkg

/* File: dbv_regs.sv */
// Dual buck control bank: two-wire serial slave, registers and voltage slewing
//
// Operation
// R1 - Seven bit code, 10 mV per step
// R2 - Code 0 is 0.68 V, 7F 1.95 V
// R3 - Go bit applies the programmed code
// R4 - Command bits 6..4 hold slew rate
// R5 - One step per 2^n cycles
// R6 - Mode field 00 follows mode pin
// R7 - Mode 10 automatic; 11 reserved, do not write
// R8 - Command bit 0 disables the output
// R9 - Mode 01 forces fixed frequency
// R10 - Write is address, register, data, each acknowledged
// R11 - Strap picks one of three addresses
// R12 - No updates while both enable pins low
`timescale 1ns/1ps
module dbv_regs (
  input  wire logic                  clk_i,            // 50 MHz system clock
  input  wire logic                  reset_n_i,        // Async reset, active low
  input  wire logic                  scl_i,            // Serial clock pin
  input  wire logic                  sda_i,            // Serial data pin level
  output logic                       sda_o,            // Serial data drive value (always 0)
  output logic                       sda_oe_o,         // Serial data pulled low when high
  input  wire logic [1:0]            addr_strap_i,     // Strap: 0 gnd, 1 high, 2 open
  input  wire logic                  ch1_hw_enable_pin_i, // Channel 1 enable pin
  input  wire logic                  ch2_hw_enable_pin_i, // Channel 2 enable pin
  input  wire logic                  mode_pin_i,       // Mode pin, 1 selects fixed frequency
  input  wire logic                  pgood1_i,         // Channel 1 power good
  input  wire logic                  pgood2_i,         // Channel 2 power good
  input  wire logic                  temp_warn_i,      // Die temperature warning
  input  wire logic                  cycle_tick_i,     // One pulse per switching cycle
  output dbv_pkg::dbv_chan_ctrl_t    ch1_ctrl_o,       // Channel 1 control
  output dbv_pkg::dbv_chan_ctrl_t    ch2_ctrl_o        // Channel 2 control
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; stage one is read only by stage two
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic [10:0] sync_in;
  assign sync_in = {scl_i, sda_i, ch1_hw_enable_pin_i, ch2_hw_enable_pin_i, mode_pin_i,
                    pgood1_i, pgood2_i, temp_warn_i, cycle_tick_i, addr_strap_i};
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1 <= 11'h7FF;
      sync2 <= 11'h7FF;
    end
    else
    begin
      sync1 <= sync_in;
      sync2 <= sync1;
    end
  end
  logic scl_s, sda_s, en1_s, en2_s, mode_s, pg1_s, pg2_s, temp_s, tick_s;
  logic [1:0] strap_s;
  assign {scl_s, sda_s, en1_s, en2_s, mode_s, pg1_s, pg2_s, temp_s, tick_s, strap_s} = sync2;

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave state
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_DATA, ST_ACK, ST_RD, ST_RACK}
    dbv_state_t;
  dbv_state_t  state, next_state, ret_state;
  dbv_state_t  next_ret_state;
  logic        scl_d, sda_d, next_scl_d, next_sda_d;
  logic [7:0]  shreg, next_shreg;
  logic [3:0]  bitcnt, next_bitcnt;
  logic [7:0]  regptr, next_regptr;
  logic        rnw, next_rnw;
  logic        drive_low, next_drive_low;
  logic        wr_pulse, next_wr_pulse;
  logic [7:0]  wr_data, next_wr_data;
  logic [6:0]  my_addr, next_my_addr;
  logic        strap_taken, next_strap_taken;
  logic [7:0]  vsel1, vsel2, cmd1, cmd2, next_vsel1, next_vsel2, next_cmd1, next_cmd2;

  // Register read mux, unmapped offsets read as zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] v1,
                                        input logic [7:0] v2, input logic [7:0] c1,
                                        input logic [7:0] c2, input logic [7:0] st);
    unique case (a)
      dbv_pkg::OFS_CH1_VSEL: rd_mux = v1;
      dbv_pkg::OFS_CH2_VSEL: rd_mux = v2;
      dbv_pkg::OFS_CH1_CMD:  rd_mux = c1;
      dbv_pkg::OFS_CH2_CMD:  rd_mux = c2;
      dbv_pkg::OFS_SYS_COND: rd_mux = st;
      default:               rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  logic [7:0] status_val;
  always_comb
  begin
    status_val = 8'h00;
    status_val[dbv_pkg::TEMP_BIT] = temp_s;
    status_val[dbv_pkg::PG2_BIT]  = pg2_s;
    status_val[dbv_pkg::PG1_BIT]  = pg1_s;
  end

  logic start_c, stop_c, scl_rise, scl_fall, hw_shutdown;
  assign start_c  = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c   = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign hw_shutdown = !en1_s && !en2_s;  // R12

  // Next-state logic for the serial slave and register writes
  always_comb
  begin
    next_state       = state;
    next_ret_state   = ret_state;
    next_scl_d       = scl_s;
    next_sda_d       = sda_s;
    next_shreg       = shreg;
    next_bitcnt      = bitcnt;
    next_regptr      = regptr;
    next_rnw         = rnw;
    next_drive_low   = drive_low;
    next_wr_pulse    = 1'b0;
    next_wr_data     = wr_data;
    next_my_addr     = my_addr;
    next_strap_taken = 1'b1;
    // Strap is static; following its synchronised level means the sync's
    // reset value selects the base address for the first two cycles only
    unique case (strap_s)  // R11
      dbv_pkg::STRAP_HIGH: next_my_addr = dbv_pkg::BUS_ADDR_BASE + 7'h1;
      dbv_pkg::STRAP_OPEN: next_my_addr = dbv_pkg::BUS_ADDR_BASE + 7'h2;
      default:             next_my_addr = dbv_pkg::BUS_ADDR_BASE;
    endcase
    if (start_c)
    begin
      next_state     = ST_ADDR;
      next_bitcnt    = 4'h0;
      next_drive_low = 1'b0;
    end
    else if (stop_c)
    begin
      next_state     = ST_IDLE;
      next_drive_low = 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE: next_drive_low = 1'b0;
        ST_ADDR, ST_REG, ST_DATA:  // R10
        begin
          if (scl_rise)
          begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == 4'h8)
          begin
            next_bitcnt = 4'h0;
            next_state  = ST_ACK;
            next_drive_low = 1'b1;
            if (state == ST_ADDR)
            begin
              next_rnw = shreg[0];
              if (shreg[7:1] != my_addr)
              begin
                next_state     = ST_IDLE;
                next_drive_low = 1'b0;
              end
              else if (shreg[0])
              begin
                next_ret_state = ST_RD;
                next_shreg     = rd_mux(regptr, vsel1, vsel2, cmd1, cmd2, status_val);
              end
              else
                next_ret_state = ST_REG;
            end
            else if (state == ST_REG)
            begin
              next_regptr    = shreg;
              next_ret_state = ST_DATA;
            end
            else
            begin
              next_wr_pulse  = !hw_shutdown;  // R12
              next_wr_data   = shreg;
              next_regptr    = regptr + 8'h1;
              next_ret_state = ST_DATA;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            next_state     = ret_state;
            next_drive_low = (ret_state == ST_RD) ? !shreg[7] : 1'b0;
          end
        end
        ST_RD:
        begin
          if (scl_fall)
          begin
            next_bitcnt = bitcnt + 4'h1;
            next_shreg  = {shreg[6:0], 1'b0};
            if (bitcnt == 4'h7)
            begin
              next_state     = ST_RACK;
              next_drive_low = 1'b0;
              next_bitcnt    = 4'h0;
            end
            else
              next_drive_low = !shreg[6];
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
              next_state = ST_IDLE;  // Master NACK ends the read
            else
            begin
              next_regptr = regptr + 8'h1;
              next_shreg  = rd_mux(regptr + 8'h1, vsel1, vsel2, cmd1, cmd2, status_val);
            end
          end
          if (scl_fall && next_state == ST_RACK)
          begin
            next_state     = ST_RD;
            next_drive_low = !shreg[7];
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Register file updates on a received data byte
  always_comb
  begin
    next_vsel1 = vsel1;
    next_vsel2 = vsel2;
    next_cmd1  = cmd1;
    next_cmd2  = cmd2;
    if (wr_pulse)
    begin
      unique case (regptr - 8'h1)
        dbv_pkg::OFS_CH1_VSEL: next_vsel1 = wr_data;
        dbv_pkg::OFS_CH2_VSEL: next_vsel2 = wr_data;
        dbv_pkg::OFS_CH1_CMD:  next_cmd1  = wr_data & dbv_pkg::CMD_WR_MASK;  // R4 R8
        dbv_pkg::OFS_CH2_CMD:  next_cmd2  = wr_data & dbv_pkg::CMD_WR_MASK;  // R4 R8
        default:               next_vsel1 = vsel1;
      endcase
    end
  end

  // Serial slave and register file flops
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state       <= ST_IDLE;
      ret_state   <= ST_IDLE;
      scl_d       <= 1'b1;
      sda_d       <= 1'b1;
      shreg       <= 8'h00;
      bitcnt      <= 4'h0;
      regptr      <= 8'h00;
      rnw         <= 1'b0;
      drive_low   <= 1'b0;
      wr_pulse    <= 1'b0;
      wr_data     <= 8'h00;
      my_addr     <= dbv_pkg::BUS_ADDR_BASE;
      strap_taken <= 1'b0;
      vsel1       <= dbv_pkg::VSEL_RESET;
      vsel2       <= dbv_pkg::VSEL_RESET;
      cmd1        <= dbv_pkg::CMD_RESET;
      cmd2        <= dbv_pkg::CMD_RESET;
    end
    else
    begin
      state       <= next_state;
      ret_state   <= next_ret_state;
      scl_d       <= next_scl_d;
      sda_d       <= next_sda_d;
      shreg       <= next_shreg;
      bitcnt      <= next_bitcnt;
      regptr      <= next_regptr;
      rnw         <= next_rnw;
      drive_low   <= next_drive_low;
      wr_pulse    <= next_wr_pulse;
      wr_data     <= next_wr_data;
      my_addr     <= next_my_addr;
      strap_taken <= next_strap_taken;
      vsel1       <= next_vsel1;
      vsel2       <= next_vsel2;
      cmd1        <= next_cmd1;
      cmd2        <= next_cmd2;
    end
  end
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_low;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel slewing toward the go-qualified code; code maps linearly 0.68 V .. 1.95 V
  logic [6:0] tgt [2];
  logic [6:0] next_tgt [2];
  logic [7:0] slew_cnt [2];
  logic [7:0] next_slew_cnt [2];
  logic [7:0] vsel_a [2];
  logic [7:0] cmd_a [2];
  assign vsel_a[0] = vsel1;
  assign vsel_a[1] = vsel2;
  assign cmd_a[0]  = cmd1;
  assign cmd_a[1]  = cmd2;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      next_tgt[c]      = tgt[c];
      next_slew_cnt[c] = slew_cnt[c];
      // Go bit gates the new code; without it the target holds
      if (vsel_a[c][dbv_pkg::GO_BIT] && tick_s && tgt[c] != vsel_a[c][6:0])  // R3
      begin
        // One 10 mV step after 2^n switching cycles
        if (slew_cnt[c] >= ((8'h01 << cmd_a[c][dbv_pkg::SLEW_LSB +: 3]) - 8'h01))  // R5
        begin
          next_slew_cnt[c] = 8'h00;
          next_tgt[c] = (tgt[c] < vsel_a[c][6:0]) ? tgt[c] + 7'h01 : tgt[c] - 7'h01;  // R1 R2
        end
        else
          next_slew_cnt[c] = slew_cnt[c] + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tgt[0] <= 7'h00;
      tgt[1] <= 7'h00;
      slew_cnt[0] <= 8'h00;
      slew_cnt[1] <= 8'h00;
    end
    else
    begin
      tgt <= next_tgt;
      slew_cnt <= next_slew_cnt;
    end
  end

  // Light-load mode decode: pin, forced fixed frequency, or automatic
  function automatic logic mode_fixed(input logic [1:0] f, input logic pin);
    unique case (f)
      dbv_pkg::MODE_PIN:    mode_fixed = pin;   // R6
      dbv_pkg::MODE_FORCED: mode_fixed = 1'b1;  // R9
      default:              mode_fixed = 1'b0;  // R7
    endcase
  endfunction : mode_fixed

  // Output control register
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ch1_ctrl_o <= '0;
      ch2_ctrl_o <= '0;
    end
    else
    begin
      ch1_ctrl_o <= {tgt[0], mode_fixed(cmd1[dbv_pkg::MODE_LSB +: 2], mode_s),
                     cmd1[dbv_pkg::OFF_BIT]};  // R8
      ch2_ctrl_o <= {tgt[1], mode_fixed(cmd2[dbv_pkg::MODE_LSB +: 2], mode_s),
                     cmd2[dbv_pkg::OFF_BIT]};  // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_no_write_in_shutdown;  // R12
    @(posedge clk_i) disable iff (!reset_n_i) hw_shutdown |=> !wr_pulse;
  endproperty
  a_no_write_in_shutdown: assert property (p_no_write_in_shutdown)  // R12
    else $error("Register write during hardware shutdown");
  property p_hold_without_go;  // R3
    @(posedge clk_i) disable iff (!reset_n_i) !vsel1[dbv_pkg::GO_BIT] |=> $stable(tgt[0]);
  endproperty
  a_hold_without_go: assert property (p_hold_without_go)  // R3
    else $error("Target moved without go bit");
  property p_single_step;  // R1
    @(posedge clk_i) disable iff (!reset_n_i)
      (tgt[0] != $past(tgt[0])) |->
        (tgt[0] == $past(tgt[0]) + 7'h01 || tgt[0] == $past(tgt[0]) - 7'h01);
  endproperty
  a_single_step: assert property (p_single_step)  // R1
    else $error("Target moved by more than one step");
  property p_fast_slew;  // R5
    @(posedge clk_i) disable iff (!reset_n_i)
      (cmd1[6:4] == 3'h0 && vsel1[7] && tick_s && tgt[0] < vsel1[6:0]) |=>
        tgt[0] == $past(tgt[0]) + 7'h01;
  endproperty
  a_fast_slew: assert property (p_fast_slew)  // R5
    else $error("Slew code 0 did not step each cycle");
  property p_mode_forced;  // R9
    @(posedge clk_i) disable iff (!reset_n_i) cmd1[2:1] == 2'h1 |=> ch1_ctrl_o.fixed_freq;
  endproperty
  a_mode_forced: assert property (p_mode_forced)  // R9
    else $error("Forced mode not fixed frequency");
  property p_mode_pin;  // R6
    @(posedge clk_i) disable iff (!reset_n_i)
      cmd2[2:1] == 2'h0 |=> ch2_ctrl_o.fixed_freq == $past(mode_s);
  endproperty
  a_mode_pin: assert property (p_mode_pin)  // R6
    else $error("Mode does not follow pin");
  property p_mode_auto;  // R7
    @(posedge clk_i) disable iff (!reset_n_i) cmd1[2:1] == 2'h2 |=> !ch1_ctrl_o.fixed_freq;
  endproperty
  a_mode_auto: assert property (p_mode_auto)  // R7
    else $error("Auto mode shows fixed frequency");
  property p_off;  // R8
    @(posedge clk_i) disable iff (!reset_n_i) 1'b1 |=> ch2_ctrl_o.output_off == $past(cmd2[0]);
  endproperty
  a_off: assert property (p_off)  // R8
    else $error("Output off does not follow command bit");
  property p_cmd_reserved;  // R4
    @(posedge clk_i) disable iff (!reset_n_i) cmd1[7] == 1'b0 && cmd1[3] == 1'b0;
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved)  // R4
    else $error("Reserved command bit set");
  property p_addr_strap;  // R11
    @(posedge clk_i) disable iff (!reset_n_i)
      strap_taken |-> my_addr[6:2] == dbv_pkg::BUS_ADDR_BASE[6:2];
  endproperty
  a_addr_strap: assert property (p_addr_strap)  // R11
    else $error("Bus address outside strap range");
  property p_ack_after_byte;  // R10
    @(posedge clk_i) disable iff (!reset_n_i) state == ST_ACK |-> drive_low;
  endproperty
  a_ack_after_byte: assert property (p_ack_after_byte)  // R10
    else $error("No acknowledge after byte");

endmodule : dbv_regs

/* File: dbv_master_model.sv */
// Two-wire bus master model that drives the serial clock and pulls the data line
`timescale 1ns/1ps
module dbv_master_model #(
  parameter int Q = 8                   // Clock cycles per quarter bit
) (
  input  wire logic clk_i,              // System clock
  input  wire logic sda_i,              // Resolved data line level
  output logic      scl_o,              // Serial clock, idles high
  output logic      sda_oe_o            // High pulls data low
);
  ////////////////////////////////////////////////////////////////////////////////
  // Lines released at time zero, so the pull-up shows idle
  initial
  begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic qwait(input int n);
    repeat (n * Q) @(posedge clk_i);
  endtask : qwait

  // Start and repeated start: data falls while clock is high
  task automatic start();
    sda_oe_o <= 1'b0;
    qwait(1);
    scl_o <= 1'b1;
    qwait(1);
    sda_oe_o <= 1'b1;
    qwait(1);
    scl_o <= 1'b0;
    qwait(1);
  endtask : start

  // Data changes only while clock is low; sampled mid high phase
  task automatic bit_xfer(input logic b, output logic s);
    sda_oe_o <= ~b;
    qwait(1);
    scl_o <= 1'b1;
    qwait(1);
    s = sda_i;
    qwait(1);
    scl_o <= 1'b0;
    qwait(1);
  endtask : bit_xfer

  // Byte out MSB first, then ninth bit released for the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask : wbyte

  // Byte in; last byte answered with a not-acknowledge
  task automatic rbyte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(last, s);
  endtask : rbyte

  // Stop: data rises while clock is high, bus left idle
  task automatic stop();
    sda_oe_o <= 1'b1;
    qwait(1);
    scl_o <= 1'b1;
    qwait(1);
    sda_oe_o <= 1'b0;
    qwait(2);
  endtask : stop
endmodule : dbv_master_model

/* File: dbv_regs_tb_top.sv */
// Self-checking testbench for the dual buck control register bank
`timescale 1ns/1ps
module dbv_regs_tb_top;
  logic clk_i, reset_n_i, scl, m_oe, sda_w, sda_o, sda_oe_o;
  logic en1, en2, mode_pin, pg1, pg2, temp, tick;
  logic [1:0] strap;
  logic [6:0] dev;
  logic [7:0] rd;
  dbv_pkg::dbv_chan_ctrl_t c1, c2;
  int failures, n_checks;

  // Open-drain data line with pull-up: low if either party pulls
  assign sda_w = ~(sda_oe_o | m_oe);

  dbv_regs dbv_regs_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_i(strap), .ch1_hw_enable_pin_i(en1),
    .ch2_hw_enable_pin_i(en2), .mode_pin_i(mode_pin), .pgood1_i(pg1), .pgood2_i(pg2),
    .temp_warn_i(temp), .cycle_tick_i(tick), .ch1_ctrl_o(c1), .ch2_ctrl_o(c2));
  dbv_master_model dbv_master_model_i (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_oe_o(m_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_ctrl(input string nm, input dbv_pkg::dbv_chan_ctrl_t e,
                          input dbv_pkg::dbv_chan_ctrl_t g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_ctrl

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles; a refused address ends the frame at once
  task automatic reg_write(input logic [6:0] a7, input logic [7:0] ra, input logic [7:0] d,
                           input logic ok);
    logic ack;
    dbv_master_model_i.start();
    dbv_master_model_i.wbyte({a7, 1'b0}, ack);
    chk_byte("address ack", {7'h00, ok}, {7'h00, ack});
    if (ok)
    begin
      dbv_master_model_i.wbyte(ra, ack);
      chk_byte("register ack", 8'h01, {7'h00, ack});
      dbv_master_model_i.wbyte(d, ack);
      chk_byte("data ack", 8'h01, {7'h00, ack});
    end
    dbv_master_model_i.stop();
  endtask : reg_write

  task automatic reg_read(input logic [7:0] ra, output logic [7:0] d);
    logic ack;
    dbv_master_model_i.start();
    dbv_master_model_i.wbyte({dev, 1'b0}, ack);
    dbv_master_model_i.wbyte(ra, ack);
    dbv_master_model_i.start();
    dbv_master_model_i.wbyte({dev, 1'b1}, ack);
    dbv_master_model_i.rbyte(d, 1'b1);
    dbv_master_model_i.stop();
  endtask : reg_read

  task automatic rd_chk(input logic [7:0] ra, input logic [7:0] e);
    reg_read(ra, rd);
    chk_byte("register readback", e, rd);
  endtask : rd_chk

  // Ticks are one clock wide, then time for the two-flop sync to settle
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i) tick <= 1'b1;
      @(posedge clk_i) tick <= 1'b0;
      @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask : ticks

  task automatic do_reset(input logic [1:0] s);
    @(posedge clk_i) reset_n_i <= 1'b0;
    strap <= s;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    dev = dbv_pkg::BUS_ADDR_BASE | {5'h00, s};
    repeat (6) @(posedge clk_i);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 4; i++) rd_chk(i[7:0], 8'h00);
    chk_ctrl("ch1 ctrl", 9'h000, c1);
    chk_ctrl("ch2 ctrl", 9'h000, c2);
  endtask : t_reset

  // Reserved bits read zero; mode codes 00 (pin), 01, 10 and off bit
  task automatic t_cmd();
    reg_write(dev, 8'h02, 8'hFD, 1'b1);
    rd_chk(8'h02, 8'h75);
    chk_ctrl("ch1 off auto", 9'h001, c1);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk_i) mode_pin <= p[0];
      reg_write(dev, 8'h02, 8'h00, 1'b1);
      chk_ctrl("ch1 pin mode", {7'h00, p[0], 1'b0}, c1);
    end
    reg_write(dev, 8'h02, 8'h02, 1'b1);
    chk_ctrl("ch1 forced", 9'h002, c1);
    reg_write(dev, 8'h02, 8'h00, 1'b1);
  endtask : t_cmd

  // Go gating, one step per tick at rate 0, one per four at rate 2
  task automatic t_slew();
    reg_write(dev, 8'h00, 8'h05, 1'b1);
    ticks(4);
    chk_byte("target without go", 8'h00, {1'b0, c1.target_code});
    reg_write(dev, 8'h00, 8'h85, 1'b1);
    ticks(4);
    chk_byte("target rate 0", 8'h04, {1'b0, c1.target_code});
    ticks(3);
    chk_byte("target settled", 8'h05, {1'b0, c1.target_code});
    reg_write(dev, 8'h02, 8'h20, 1'b1);
    reg_write(dev, 8'h00, 8'h87, 1'b1);
    ticks(4);
    chk_byte("rate 2 early", 8'h06, {1'b0, c1.target_code});
    ticks(4);
    chk_byte("target rate 2", 8'h07, {1'b0, c1.target_code});
    reg_write(dev, 8'h01, 8'hFF, 1'b1);
    ticks(127);
    chk_byte("target full scale", 8'h7F, {1'b0, c2.target_code});
  endtask : t_slew

  // Hardware shutdown drops writes; one enable keeps the bank live
  task automatic t_shutdown();
    @(posedge clk_i) en1 <= 1'b0;
    en2 <= 1'b0;
    reg_write(dev, 8'h01, 8'h90, 1'b1);
    @(posedge clk_i) en1 <= 1'b1;
    rd_chk(8'h01, 8'hFF);
    reg_write(dev, 8'h03, 8'h01, 1'b1);
    rd_chk(8'h03, 8'h01);
    // Mode pin was left high by the mode scenario, so pin mode shows fixed frequency
    chk_ctrl("ch2 off", {7'h7F, 1'b1, 1'b1}, c2);
    @(posedge clk_i) en2 <= 1'b1;
  endtask : t_shutdown

  // Status is read-only; unmapped reads zero
  task automatic t_map();
    @(posedge clk_i) temp <= 1'b1;
    pg1 <= 1'b1;
    reg_write(dev, 8'h04, 8'hFF, 1'b1);
    rd_chk(8'h04, 8'h05);
    rd_chk(8'h05, 8'h00);
  endtask : t_map

  // Each strap setting answers its own address and refuses the next setting's address
  task automatic t_strap();
    for (int s = 0; s < 3; s++)
    begin
      do_reset(s[1:0]);
      reg_write(dbv_pkg::BUS_ADDR_BASE + 7'((s + 1) % 3), 8'h00, 8'h11, 1'b0);
      reg_write(dev, 8'h00, 8'h01, 1'b1);
      rd_chk(8'h00, 8'h01);
    end
  endtask : t_strap

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    failures = 0;
    n_checks = 0;
    reset_n_i = 1'b0;
    strap = 2'h0;
    dev = dbv_pkg::BUS_ADDR_BASE;
    {en1, en2, mode_pin, pg1, pg2, temp, tick} = 7'h60;
    do_reset(2'h0);
    t_reset();
    t_cmd();
    t_slew();
    t_shutdown();
    t_map();
    t_strap();
    conclude();
  end

  // Watchdog well beyond the expected run of about 31k cycles
  initial
  begin
    repeat (95000) @(posedge clk_i);
    failures++;
    conclude();
  end
endmodule : dbv_regs_tb_top
